// ==== rtl/chan_ctrl_defs.vh ====
// Constants for the channel control register pair
`ifndef CHAN_CTRL_DEFS_VH
`define CHAN_CTRL_DEFS_VH

// Control word layout
`define CW_ADDR_HI        15
`define CW_ADDR_LO        13
`define CW_RW_BIT         12
`define CW_DATA_HI        7
`define CW_DATA_LO        0

// Register numbers
`define REG_CTRL_ONE      3'h1
`define REG_CTRL_TWO      3'h2

// First register fields
`define C1_ADC_OVF        7
`define C1_CONT_XFER      6
`define C1_RECURSIVE      5
`define C1_DAC_OVF        4
`define C1_BIAS           3
`define C1_ANALOG_LB      2
`define C1_DIGITAL_LB     1
`define C1_DAC_WIDTH      0

// Second register fields
`define C2_TURBO          7
`define C2_BYPASS         6
`define C2_ADDR_HI        5
`define C2_ADDR_LO        3
`define C2_GPO            2
`define C2_HPC_HI         1
`define C2_HPC_LO         0

// Reset values
`define RST_CTRL_ONE_BIT  1'b0
`define RST_ADDR_MSBS     3'h4
`define RST_HPC           2'h0
`define RST_CTRL_TWO_BIT  1'b0

// Host pin configurations
`define HPC_I2C           2'h0
`define HPC_START_STOP    2'h1
`define HPC_GPO_ROUTE     2'h2
`define HPC_FRAME_FLAG    2'h3

// Bit clock: bits per device per frame
`define BITS_PER_DEVICE   11'h010

`endif

// ==== rtl/bit_clock_gen.v ====
// Bit clock generator by rational rate accumulation
`timescale 1ns/1ps
module bit_clock_gen (
	input  wire        ref_clk,
	input  wire        reset_n,
	input  wire        clk_en,
	input  wire [10:0] half_bits_num,
	input  wire [15:0] cycles_den,
	output reg         bit_clock
);
	reg  [16:0] acc_r;
	reg  [16:0] acc_nxt;
	reg         tick;
	wire [16:0] den;
	wire [16:0] sum;

	// A zero divisor is treated as one to keep the clock alive
	assign den = (cycles_den == 16'h0000) ? 17'h00001 : {1'b0, cycles_den};
	assign sum = acc_r + {6'h00, half_bits_num};

	always @* begin
		tick    = 1'b0;
		acc_nxt = sum;
		if (sum >= den) begin
			tick    = 1'b1;
			acc_nxt = sum - den;
			// A residue left from a slower ratio would burst; restart it
			if (acc_nxt >= den)
				acc_nxt = 17'h00000;
		end
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_r     <= 17'h00000;
			bit_clock <= 1'b0;
		end else if (clk_en) begin
			acc_r <= acc_nxt;
			if (tick)
				bit_clock <= ~bit_clock;
		end
	end
endmodule // bit_clock_gen

// ==== rtl/host_pin_mux.v ====
// Host pin routing for the two host pins
`timescale 1ns/1ps
`include "chan_ctrl_defs.vh"
module host_pin_mux (
	input  wire [1:0] host_pin_config,
	input  wire       general_output_bit,
	input  wire       ctrl_frame_flag,
	input  wire       scl_in,
	input  wire       engine_sda_out,
	input  wire       engine_sda_oe_n,
	output reg        i2c_link_enable,
	output reg        start_stop_host_link,
	output reg        sda_out,
	output reg        sda_oe_n,
	output reg        dout_route_enable,
	output reg        dout_route_value
);
	always @* begin
		i2c_link_enable      = 1'b0;
		start_stop_host_link = 1'b0;
		sda_out              = engine_sda_out;
		sda_oe_n             = engine_sda_oe_n;
		dout_route_enable    = 1'b0;
		dout_route_value     = 1'b0;
		case (host_pin_config)
		`HPC_I2C: begin
			i2c_link_enable = 1'b1;
		end
		`HPC_START_STOP: begin
			start_stop_host_link = 1'b1;
		end
		`HPC_GPO_ROUTE: begin
			sda_out           = general_output_bit;
			sda_oe_n          = 1'b0;
			dout_route_enable = 1'b1;
			dout_route_value  = scl_in;
		end
		`HPC_FRAME_FLAG: begin
			sda_out  = ctrl_frame_flag;
			sda_oe_n = 1'b0;
		end
		default: begin
			i2c_link_enable = 1'b0;
		end
		endcase
	end
endmodule // host_pin_mux

// ==== rtl/codec_control_regs_one_two.v ====
// First two control registers of both codec channels
`timescale 1ns/1ps
`include "chan_ctrl_defs.vh"

// Overview of operation
// - Read-only bit 7 reports ADC overflow
// - Read-only bit 4 reports DAC overflow
// - Bit 6 selects programming or continuous mode
// - Bit 5 selects FIR or RECURSIVE_FILTER_SELECT filter
// - Bit 3 selects bias output level
// - Bit 2 enables analog loopback
// - Bit 1 enables digital loopback
// - Bit 0 sets DAC word width, continuous only
// - Set LSB of 15-bit word exits continuous
// - Normal bit clock from frame, devices, mode
// - Turbo bit clock is master clock over P
// - Second register bit 6 bypasses rate filters
// - Bits 5:3 are address MSBs, reset 100
// - Pin field selects I2C or start-stop link
// - Field 10 drives GENERAL_OUTPUT_BIT, routes clock pin
// - Field 11 drives the control frame flag
// - Mode, bias, width and register two shadowed
// - Shadowed writes update the one copy both channels share
// - Word holds register, read flag and data
module codec_control_regs_one_two (
	input  wire        ref_clk,
	input  wire        reset_n,
	input  wire        clk_en,
	input  wire        cw_valid,
	input  wire [15:0] cw_word,
	input  wire        cw_channel,
	output reg         rd_valid,
	output reg  [7:0]  rd_data,
	input  wire [1:0]  adc_overflow_event,
	input  wire [1:0]  dac_overflow_event,
	input  wire        dac_word_valid,
	input  wire        dac_word_lsb,
	input  wire [3:0]  cascade_position,
	input  wire [3:0]  cascade_count,
	input  wire [1:0]  mode_factor,
	input  wire [15:0] frame_cycles,
	input  wire [7:0]  turbo_divisor,
	input  wire        scl_in,
	input  wire        engine_sda_out,
	input  wire        engine_sda_oe_n,
	input  wire        ctrl_frame_flag,
	output wire [1:0]  adc_overflow_flag,
	output wire [1:0]  dac_overflow_flag,
	output wire        continuous_transfer_select,
	output wire [1:0]  recursive_filter_select,
	output wire        bias_level_select,
	output wire [1:0]  analog_loopback_enable,
	output wire [1:0]  digital_loopback_enable,
	output wire        dac_word_width_select,
	output wire        effective_word_16,
	output wire        rate_filter_bypass,
	output wire        turbo_select,
	output wire [6:0]  host_address,
	output wire        general_output_bit,
	output wire [1:0]  host_pin_config,
	output wire        i2c_link_enable,
	output wire        start_stop_host_link,
	output wire        sda_out,
	output wire        sda_oe_n,
	output wire        dout_route_enable,
	output wire        dout_route_value,
	output wire        bit_clock
);
	// Shadowed state: one copy serves both channels
	reg        cont_xfer_r;
	reg        bias_r;
	reg        dac_width_r;
	reg        turbo_r;
	reg        bypass_r;
	reg  [2:0] addr_msbs_r;
	reg        gpo_r;
	reg  [1:0] hpc_r;

	// Next values of the shadowed state
	reg        cont_xfer_nxt;
	reg        bias_nxt;
	reg        dac_width_nxt;
	reg        turbo_nxt;
	reg        bypass_nxt;
	reg  [2:0] addr_msbs_nxt;
	reg        gpo_nxt;
	reg  [1:0] hpc_nxt;

	// Per-channel state
	reg  [1:0] recursive_r;
	reg  [1:0] analog_lb_r;
	reg  [1:0] digital_lb_r;
	reg  [1:0] adc_ovf_r;
	reg  [1:0] dac_ovf_r;

	// Next values of the per-channel state
	reg  [1:0] recursive_nxt;
	reg  [1:0] analog_lb_nxt;
	reg  [1:0] digital_lb_nxt;
	reg  [1:0] adc_ovf_nxt;
	reg  [1:0] dac_ovf_nxt;

	wire       wr_one;
	wire       wr_two;
	wire       rd_one;
	wire       rd_two;
	wire [7:0] wdata;
	wire       exit_cont;
	wire [7:0] ctrl_one_view;
	wire [7:0] ctrl_two_view;
	reg  [10:0] half_bits;
	reg  [15:0] rate_den;
	wire [10:0] bits_per_frame;

	// Next values of the read return
	reg         rd_valid_nxt;
	reg  [7:0]  rd_data_nxt;
	wire [1:0]  chan_sel;
	wire [1:0]  chan_clear;

	localparam [10:0] bits_per_dev = `BITS_PER_DEVICE;

	// Match a control word against a register number and direction
	function reg_hit;
		input [15:0] word;
		input [2:0]  regnum;
		input        rd;
		begin
			reg_hit = (word[`CW_ADDR_HI:`CW_ADDR_LO] == regnum) &&
				(word[`CW_RW_BIT] == rd);
		end
	endfunction

	assign wr_one = cw_valid &&
		reg_hit(cw_word, `REG_CTRL_ONE, 1'b0);
	assign wr_two = cw_valid &&
		reg_hit(cw_word, `REG_CTRL_TWO, 1'b0);
	assign rd_one = cw_valid &&
		reg_hit(cw_word, `REG_CTRL_ONE, 1'b1);
	assign rd_two = cw_valid &&
		reg_hit(cw_word, `REG_CTRL_TWO, 1'b1);
	assign wdata  = cw_word[`CW_DATA_HI:`CW_DATA_LO];

	// A set LSB on a 15-bit DAC word drops back to programming mode
	assign exit_cont = dac_word_valid && cont_xfer_r && !dac_width_r &&
		dac_word_lsb;

	// Next values of the shadowed fields of both registers
	always @* begin
		cont_xfer_nxt = cont_xfer_r;
		bias_nxt      = bias_r;
		dac_width_nxt = dac_width_r;
		turbo_nxt     = turbo_r;
		bypass_nxt    = bypass_r;
		addr_msbs_nxt = addr_msbs_r;
		gpo_nxt       = gpo_r;
		hpc_nxt       = hpc_r;
		if (wr_one) begin
			// Same copy for both channels, whichever one wrote
			cont_xfer_nxt = wdata[`C1_CONT_XFER];
			bias_nxt      = wdata[`C1_BIAS];
			dac_width_nxt = wdata[`C1_DAC_WIDTH];
		end else if (exit_cont) begin
			cont_xfer_nxt = 1'b0;
		end
		if (wr_two) begin
			turbo_nxt     = wdata[`C2_TURBO];
			bypass_nxt    = wdata[`C2_BYPASS];
			addr_msbs_nxt = wdata[`C2_ADDR_HI:`C2_ADDR_LO];
			gpo_nxt       = wdata[`C2_GPO];
			hpc_nxt       = wdata[`C2_HPC_HI:`C2_HPC_LO];
		end
	end

	// Shadowed fields of both registers
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cont_xfer_r <= `RST_CTRL_ONE_BIT;
			bias_r      <= `RST_CTRL_ONE_BIT;
			dac_width_r <= `RST_CTRL_ONE_BIT;
			turbo_r     <= `RST_CTRL_TWO_BIT;
			bypass_r    <= `RST_CTRL_TWO_BIT;
			addr_msbs_r <= `RST_ADDR_MSBS;
			gpo_r       <= `RST_CTRL_TWO_BIT;
			hpc_r       <= `RST_HPC;
		end else if (clk_en) begin
			cont_xfer_r <= cont_xfer_nxt;
			bias_r      <= bias_nxt;
			dac_width_r <= dac_width_nxt;
			turbo_r     <= turbo_nxt;
			bypass_r    <= bypass_nxt;
			addr_msbs_r <= addr_msbs_nxt;
			gpo_r       <= gpo_nxt;
			hpc_r       <= hpc_nxt;
		end
	end

	// Per-channel fields and sticky overflow flags
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			assign chan_sel[ch]   = (ch == 0) ? !cw_channel : cw_channel;
			// A read of the first register clears this channel's flags
			assign chan_clear[ch] = rd_one && chan_sel[ch];
			always @* begin
				recursive_nxt[ch]  = recursive_r[ch];
				analog_lb_nxt[ch]  = analog_lb_r[ch];
				digital_lb_nxt[ch] = digital_lb_r[ch];
				if (wr_one && chan_sel[ch]) begin
					recursive_nxt[ch]  = wdata[`C1_RECURSIVE];
					analog_lb_nxt[ch]  = wdata[`C1_ANALOG_LB];
					digital_lb_nxt[ch] = wdata[`C1_DIGITAL_LB];
				end
				// Flag bits of a write are dropped; an event beats the clear
				adc_ovf_nxt[ch] = adc_ovf_r[ch];
				if (adc_overflow_event[ch])
					adc_ovf_nxt[ch] = 1'b1;
				else if (chan_clear[ch])
					adc_ovf_nxt[ch] = 1'b0;
				dac_ovf_nxt[ch] = dac_ovf_r[ch];
				if (dac_overflow_event[ch])
					dac_ovf_nxt[ch] = 1'b1;
				else if (chan_clear[ch])
					dac_ovf_nxt[ch] = 1'b0;
			end
			always @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					recursive_r[ch]  <= `RST_CTRL_ONE_BIT;
					analog_lb_r[ch]  <= `RST_CTRL_ONE_BIT;
					digital_lb_r[ch] <= `RST_CTRL_ONE_BIT;
					adc_ovf_r[ch]    <= `RST_CTRL_ONE_BIT;
					dac_ovf_r[ch]    <= `RST_CTRL_ONE_BIT;
				end else if (clk_en) begin
					recursive_r[ch]  <= recursive_nxt[ch];
					analog_lb_r[ch]  <= analog_lb_nxt[ch];
					digital_lb_r[ch] <= digital_lb_nxt[ch];
					adc_ovf_r[ch]    <= adc_ovf_nxt[ch];
					dac_ovf_r[ch]    <= dac_ovf_nxt[ch];
				end
			end
		end
	endgenerate

	// Register images as seen by the addressed channel
	assign ctrl_one_view = {
		adc_ovf_r[cw_channel],
		cont_xfer_r,
		recursive_r[cw_channel],
		dac_ovf_r[cw_channel],
		bias_r,
		analog_lb_r[cw_channel],
		digital_lb_r[cw_channel],
		dac_width_r
	};
	assign ctrl_two_view = {
		turbo_r,
		bypass_r,
		addr_msbs_r,
		gpo_r,
		hpc_r
	};

	// Read return, one cycle after the word is taken
	always @* begin
		rd_valid_nxt = rd_one | rd_two;
		rd_data_nxt  = rd_data;
		case ({rd_two, rd_one})
		2'b01: begin
			rd_data_nxt = ctrl_one_view;
		end
		2'b10: begin
			rd_data_nxt = ctrl_two_view;
		end
		default: begin
			rd_data_nxt = rd_data;
		end
		endcase
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_valid <= 1'b0;
			rd_data  <= 8'h00;
		end else if (clk_en) begin
			rd_valid <= rd_valid_nxt;
			rd_data  <= rd_data_nxt;
		end
	end

	assign adc_overflow_flag          = adc_ovf_r;
	assign dac_overflow_flag          = dac_ovf_r;
	assign continuous_transfer_select = cont_xfer_r;
	assign recursive_filter_select    = recursive_r;
	assign bias_level_select          = bias_r;
	assign analog_loopback_enable     = analog_lb_r;
	assign digital_loopback_enable    = digital_lb_r;
	assign dac_word_width_select      = dac_width_r;
	// Width choice only counts in continuous mode
	assign effective_word_16  = cont_xfer_r & dac_width_r;
	assign rate_filter_bypass = bypass_r;
	assign turbo_select       = turbo_r;
	assign host_address       = {addr_msbs_r, cascade_position};
	assign general_output_bit = gpo_r;
	assign host_pin_config    = hpc_r;

	// Two half bits per bit, for every device of the cascade
	assign bits_per_frame = {bits_per_dev[9:0], 1'b0} *
		{7'h00, cascade_count};

	// Half-bit rate as a ratio of reference cycles
	always @* begin
		if (turbo_r) begin
			half_bits = 11'h002;
			rate_den  = {8'h00, turbo_divisor};
		end else begin
			half_bits = bits_per_frame * {9'h000, mode_factor};
			rate_den  = frame_cycles;
		end
	end

	bit_clock_gen u_bit_clock (
		.ref_clk       (ref_clk),
		.reset_n       (reset_n),
		.clk_en        (clk_en),
		.half_bits_num (half_bits),
		.cycles_den    (rate_den),
		.bit_clock     (bit_clock)
	);

	host_pin_mux u_pins (
		.host_pin_config      (hpc_r),
		.general_output_bit   (gpo_r),
		.ctrl_frame_flag      (ctrl_frame_flag),
		.scl_in               (scl_in),
		.engine_sda_out       (engine_sda_out),
		.engine_sda_oe_n      (engine_sda_oe_n),
		.i2c_link_enable      (i2c_link_enable),
		.start_stop_host_link (start_stop_host_link),
		.sda_out              (sda_out),
		.sda_oe_n             (sda_oe_n),
		.dout_route_enable    (dout_route_enable),
		.dout_route_value     (dout_route_value)
	);
endmodule // codec_control_regs_one_two

// ==== tb/codec_regs_properties.sv ====
// Port assertions for the channel control register pair
`timescale 1ns/1ps
module codec_regs_properties (
	input wire        ref_clk,
	input wire        reset_n,
	input wire        clk_en,
	input wire        cw_valid,
	input wire [15:0] cw_word,
	input wire        cw_channel,
	input wire        rd_valid,
	input wire [1:0]  adc_overflow_event,
	input wire [1:0]  dac_overflow_event,
	input wire        dac_word_valid,
	input wire        dac_word_lsb,
	input wire        scl_in,
	input wire        ctrl_frame_flag,
	input wire [1:0]  adc_overflow_flag,
	input wire [1:0]  dac_overflow_flag,
	input wire        continuous_transfer_select,
	input wire [1:0]  recursive_filter_select,
	input wire        bias_level_select,
	input wire [1:0]  analog_loopback_enable,
	input wire [1:0]  digital_loopback_enable,
	input wire        dac_word_width_select,
	input wire        rate_filter_bypass,
	input wire        turbo_select,
	input wire [6:0]  host_address,
	input wire        general_output_bit,
	input wire [1:0]  host_pin_config,
	input wire        sda_out,
	input wire        sda_oe_n,
	input wire        dout_route_enable,
	input wire        dout_route_value
);
	wire take = clk_en && cw_valid;
	wire wr1 = take && cw_word[15:13] == 3'h1 && !cw_word[12];
	wire wr2 = take && cw_word[15:13] == 3'h2 && !cw_word[12];
	wire rd = take && cw_word[12] &&
		(cw_word[15:13] == 3'h1 || cw_word[15:13] == 3'h2);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_shared_one: assert property (
		wr1 |=> {continuous_transfer_select, bias_level_select,
		dac_word_width_select} == {$past(cw_word[6]), $past(cw_word[3]),
		$past(cw_word[0])}) else $error("shared reg1 bits wrong");
	a_chan_one: assert property (
		wr1 |=> recursive_filter_select[$past(cw_channel)] == $past(cw_word[5])
		&& analog_loopback_enable[$past(cw_channel)] == $past(cw_word[2])
		&& digital_loopback_enable[$past(cw_channel)] == $past(cw_word[1]))
		else $error("channel reg1 bits wrong");
	a_reg_two: assert property (
		wr2 |=> {turbo_select, rate_filter_bypass, host_address[6:4],
		general_output_bit, host_pin_config} == $past(cw_word[7:0]))
		else $error("reg2 bits wrong");
	a_read_answer: assert property (
		rd |=> rd_valid) else $error("read not answered");
	a_adc_sticky: assert property (
		clk_en && adc_overflow_event != 2'h0 |=> (adc_overflow_flag &
		$past(adc_overflow_event)) == $past(adc_overflow_event))
		else $error("adc flag not set");
	a_dac_sticky: assert property (
		clk_en && dac_overflow_event != 2'h0 |=> (dac_overflow_flag &
		$past(dac_overflow_event)) == $past(dac_overflow_event))
		else $error("dac flag not set");
	a_flag_no_write: assert property (
		wr1 && adc_overflow_event == 2'h0 && dac_overflow_event == 2'h0 &&
		!adc_overflow_flag[cw_channel] && !dac_overflow_flag[cw_channel]
		|=> !adc_overflow_flag[$past(cw_channel)] &&
		!dac_overflow_flag[$past(cw_channel)]) else $error("flag written");
	a_cont_exit: assert property (
		clk_en && dac_word_valid && dac_word_lsb && continuous_transfer_select
		&& !dac_word_width_select && !wr1 |=> !continuous_transfer_select)
		else $error("continuous mode not left");
	a_pin_gpo: assert property (
		host_pin_config == 2'h2 |-> sda_out == general_output_bit && !sda_oe_n
		&& dout_route_enable && dout_route_value == scl_in)
		else $error("gpo routing wrong");
	a_pin_flag: assert property (
		host_pin_config == 2'h3 |-> sda_out == ctrl_frame_flag && !sda_oe_n)
		else $error("frame flag routing wrong");
endmodule // codec_regs_properties

bind codec_control_regs_one_two codec_regs_properties chk (.*);

// ==== tb/host_model.sv ====
// Host model issuing control words and DAC input words
`timescale 1ns/1ps
module host_model (
	input  wire        ref_clk,
	output reg         cw_valid,
	output reg  [15:0] cw_word,
	output reg         cw_channel,
	output reg         dac_word_valid,
	output reg         dac_word_lsb
);
	initial begin
		cw_valid = 1'b0;
		cw_word = 16'h0;
		cw_channel = 1'b0;
		dac_word_valid = 1'b0;
		dac_word_lsb = 1'b0;
	end
	task acc(input [2:0] r, input w_rd, input [7:0] d, input ch);
		@(negedge ref_clk);
		cw_word <= {r, w_rd, 4'h7, d};
		cw_channel <= ch;
		cw_valid <= 1'b1;
		@(negedge ref_clk);
		cw_valid <= 1'b0;
		// Released word never repeats its last value
		cw_word <= ~cw_word;
	endtask
	task dac(input lsb);
		@(negedge ref_clk);
		dac_word_lsb <= lsb;
		dac_word_valid <= 1'b1;
		@(negedge ref_clk);
		dac_word_valid <= 1'b0;
		dac_word_lsb <= ~lsb;
	endtask
endmodule // host_model

// ==== tb/test_codec_control_regs_one_two.sv ====
// Self-checking bench for the channel control register pair
`timescale 1ns/1ps
module test_codec_control_regs_one_two;
	reg         ref_clk = 1'b0;
	reg         reset_n = 1'b0;
	reg         clk_en = 1'b1;
	reg  [1:0]  adc_overflow_event = 2'h0;
	reg  [1:0]  dac_overflow_event = 2'h0;
	reg  [3:0]  cascade_position = 4'h5;
	reg  [3:0]  cascade_count = 4'h1;
	reg  [1:0]  mode_factor = 2'h1;
	reg  [15:0] frame_cycles = 16'h0080;
	reg  [7:0]  turbo_divisor = 8'h04;
	reg         scl_in = 1'b1;
	reg         engine_sda_out = 1'b1;
	reg         engine_sda_oe_n = 1'b1;
	reg         ctrl_frame_flag = 1'b0;
	wire        cw_valid, cw_channel, dac_word_valid, dac_word_lsb, rd_valid;
	wire [15:0] cw_word;
	wire [7:0]  rd_data;
	wire [6:0]  host_address;
	wire [1:0]  adc_overflow_flag, dac_overflow_flag, host_pin_config;
	wire [1:0]  recursive_filter_select, analog_loopback_enable;
	wire [1:0]  digital_loopback_enable;
	wire        continuous_transfer_select, bias_level_select, bit_clock;
	wire        dac_word_width_select, effective_word_16, rate_filter_bypass;
	wire        turbo_select, general_output_bit, i2c_link_enable, sda_out;
	wire        start_stop_host_link, sda_oe_n, dout_route_enable;
	wire        dout_route_value;
	integer     mismatches = 0, check_count = 0, i, n, t;
	reg         last;
	always #10 ref_clk = ~ref_clk;
	codec_control_regs_one_two dut (.*);
	host_model host (.*);
	task conclude;
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string nm, input [7:0] s, input [7:0] e);
		check_count = check_count + 1;
		if (s !== e) begin
			mismatches = mismatches + 1;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task rd(input [2:0] r, input ch, input [7:0] e, input string nm);
		host.acc(r, 1'b1, 8'h00, ch);
		for (i = 0; i < 4 && rd_valid !== 1'b1; i = i + 1)
			@(negedge ref_clk);
		if (i == 4) begin
			mismatches = mismatches + 1;
			conclude;
		end else begin
			chk(nm, rd_data, e);
		end
	endtask
	task count_toggles;
		t = 0;
		last = bit_clock;
		repeat (40) begin
			@(negedge ref_clk);
			if (bit_clock !== last)
				t = t + 1;
			last = bit_clock;
		end
	endtask
	task t_reset;
		rd(3'h1, 1'b0, 8'h00, "reset reg1");
		rd(3'h2, 1'b1, 8'h20, "reset reg2");
		chk("address", {1'b0, host_address}, 8'h45);
		host.acc(3'h3, 1'b0, 8'hff, 1'b0);
		host.acc(3'h0, 1'b1, 8'h00, 1'b0);
		chk("stray answer", {7'h0, rd_valid}, 8'h00);
		rd(3'h2, 1'b0, 8'h20, "reg3 ignored");
		rd(3'h1, 1'b0, 8'h00, "reg3 not reg1");
	endtask
	task t_reg1;
		host.acc(3'h1, 1'b0, 8'hff, 1'b0);
		rd(3'h1, 1'b0, 8'h6f, "reg1 ch0");
		rd(3'h1, 1'b1, 8'h49, "reg1 ch1");
		chk("filter", {6'h0, recursive_filter_select}, 8'h01);
		chk("reg1 outs", {analog_loopback_enable, digital_loopback_enable,
			continuous_transfer_select, bias_level_select,
			dac_word_width_select, 1'b0}, 8'h5e);
		clk_en = 1'b0;
		host.acc(3'h1, 1'b0, 8'h00, 1'b0);
		clk_en = 1'b1;
		rd(3'h1, 1'b0, 8'h6f, "frozen write");
	endtask
	task t_cont;
		host.acc(3'h1, 1'b0, 8'h40, 1'b1);
		host.dac(1'b0);
		rd(3'h1, 1'b1, 8'h40, "cont kept");
		chk("narrow word", {7'h0, effective_word_16}, 8'h00);
		host.dac(1'b1);
		rd(3'h1, 1'b1, 8'h00, "cont left");
		host.acc(3'h1, 1'b0, 8'h01, 1'b1);
		chk("width unused", {7'h0, effective_word_16}, 8'h00);
		host.acc(3'h1, 1'b0, 8'h41, 1'b1);
		host.dac(1'b1);
		rd(3'h1, 1'b1, 8'h41, "wide kept");
		chk("wide word", {7'h0, effective_word_16}, 8'h01);
	endtask
	task t_ovf;
		@(negedge ref_clk);
		adc_overflow_event = 2'h2;
		dac_overflow_event = 2'h2;
		@(negedge ref_clk);
		adc_overflow_event = 2'h0;
		dac_overflow_event = 2'h0;
		chk("flags", {4'h0, adc_overflow_flag, dac_overflow_flag},
			8'h0a);
		rd(3'h1, 1'b0, 8'h67, "ovf ch0");
		rd(3'h1, 1'b1, 8'hd1, "ovf ch1");
		rd(3'h1, 1'b1, 8'h41, "ovf cleared");
	endtask
	task t_reg2;
		engine_sda_out = 1'b0;
		for (n = 0; n < 4; n = n + 1) begin
			ctrl_frame_flag = n[0];
			host.acc(3'h2, 1'b0, {5'b01011, ~n[0], n[1:0]}, n[0]);
			rd(3'h2, ~n[0], {5'b01011, ~n[0], n[1:0]}, "reg2");
			chk("pins", {2'h0, i2c_link_enable, start_stop_host_link,
				sda_out, sda_oe_n, dout_route_enable, dout_route_value},
				{2'h0, n == 0, n == 1, n[1], n < 2,
				n == 2, n == 2});
		end
		chk("address", {1'b0, host_address}, 8'h35);
		chk("reg2 outs", {5'h0, turbo_select, rate_filter_bypass,
			general_output_bit}, 8'h02);
	endtask
	task t_clk;
		host.acc(3'h2, 1'b0, 8'h00, 1'b0);
		count_toggles;
		chk("normal clock", t[7:0], 8'h0a);
		host.acc(3'h2, 1'b0, 8'h80, 1'b0);
		count_toggles;
		chk("turbo clock", t[7:0], 8'h14);
	endtask
	initial begin
		repeat (20) @(negedge ref_clk);
		reset_n = 1'b1;
		t_reset;
		t_reg1;
		t_cont;
		t_ovf;
		t_reg2;
		t_clk;
		conclude;
	end
endmodule // test_codec_control_regs_one_two
